/* File: hdl/pll_divider_lock_detect.sv */
// feedback and reference dividers, path delays, digital lock detector and pin routing
// assumes divider input pins toggle slower than a quarter of i_clock; pin levels are
// resolved outside from out/oe/src_en
// Function
// - sync pin resets R, A, B together
// - sync pin reset disabled after reset
// - three-bit delay cell in each path
// - cycle in lock when edge gap small
// - unlock window wider than lock window
// - lock after programmable consecutive good cycles
// - one cycle beyond unlock drops lock
// - windows from range bit and antibacklash
// - lock result routable to three pins
// - pull-down mode rests high, low pulses
// - pull-up mode rests low, high pulses
// - current source chosen by ld select
// - source current when locked, else ground
// - momentary unlock discharges pin at once
// - ld comparator on monitor or status
// - fixed divide ignores swallow counter
// - feedback ratio is P times B plus A
// - 14-bit reference divider, 0 and 1 divide-by-one
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pll_divider_lock_detect
	import pll_lock_pkg::*;
(
	input  wire logic                     i_clock,
	input  wire logic                     i_rst_n,
	input  wire pll_lock_pkg::reg_req_t   i_reg_req,
	output logic [pll_lock_pkg::DATA_W-1:0] o_reg_rdata,
	input  wire logic                     i_ref_pin,
	input  wire logic                     i_vco_pin,
	input  wire logic                     i_sync_n_pin,
	input  wire logic                     i_lock_ind_in,
	output pll_lock_pkg::ld_pin_t         o_lock_ind,
	output logic                          o_status_pin,
	output logic                          o_reference_monitor_pin,
	output logic                          o_pfd_ref_edge,
	output logic                          o_pfd_fb_edge,
	output logic                          o_digital_lock_result
);
	import pll_lock_pkg::*;

	logic [7:0] r_lo_r, r_hi_r, a_r, b_lo_r, b_hi_r, psc_r;
	logic [7:0] abp_stat_r, lock_cfg_r, dly_rst_r, ld_sel_r, mon_sel_r;

	// pin synchronisers: three flops, value accepted when stages two and three agree
	localparam int unsigned NPIN = 4;
	logic [NPIN-1:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_q, pin_prev;
	assign pin_raw = {i_lock_ind_in, i_sync_n_pin, i_vco_pin, i_ref_pin};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			always_ff @(posedge i_clock) begin
				if (!i_rst_n) begin
					pin_s1[gi]   <= 1'b0;
					pin_s2[gi]   <= 1'b0;
					pin_s3[gi]   <= 1'b0;
					pin_q[gi]    <= 1'b0;
					pin_prev[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					if (pin_s2[gi] == pin_s3[gi]) begin
						pin_q[gi] <= pin_s3[gi];
					end
					pin_prev[gi] <= pin_q[gi];
				end
			end
		end
	endgenerate

	logic ref_rise, vco_rise, sync_act, ld_comp;
	assign ref_rise = pin_q[0] & ~pin_prev[0];
	assign vco_rise = pin_q[1] & ~pin_prev[1];
	assign sync_act = ~pin_q[2];
	assign ld_comp  = pin_q[3];

	// register write port
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			r_lo_r     <= RST_VAL_REG;
			r_hi_r     <= RST_VAL_REG;
			a_r        <= RST_VAL_REG;
			b_lo_r     <= RST_VAL_REG;
			b_hi_r     <= RST_VAL_REG;
			psc_r      <= RST_VAL_REG;
			abp_stat_r <= RST_VAL_REG;
			lock_cfg_r <= RST_VAL_REG;
			dly_rst_r  <= RST_VAL_REG;
			ld_sel_r   <= RST_VAL_REG;
			mon_sel_r  <= RST_VAL_REG;
		end else if (i_reg_req.wr) begin
			case (i_reg_req.addr)
				OFS_R_LO:        r_lo_r     <= i_reg_req.wdata;
				OFS_R_HI:        r_hi_r     <= {2'h0, i_reg_req.wdata[5:0]};
				OFS_A_CNT:       a_r        <= {2'h0, i_reg_req.wdata[5:0]};
				OFS_B_LO:        b_lo_r     <= i_reg_req.wdata;
				OFS_B_HI:        b_hi_r     <= {3'h0, i_reg_req.wdata[4:0]};
				OFS_PRESCALER:   psc_r      <= {5'h00, i_reg_req.wdata[2:0]};
				OFS_ABP_STATUS:  abp_stat_r <= i_reg_req.wdata;
				OFS_LOCK_CFG:    lock_cfg_r <= i_reg_req.wdata;
				OFS_DELAY_RESET: dly_rst_r  <= i_reg_req.wdata;
				OFS_LD_SEL:      ld_sel_r   <= {2'h0, i_reg_req.wdata[5:0]};
				OFS_MON_SEL:     mon_sel_r  <= i_reg_req.wdata;
				default:         ;
			endcase
		end
	end

	logic dld_r;

	// read data stand only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_req.rd) begin
			case (i_reg_req.addr)
				OFS_R_LO:        o_reg_rdata <= r_lo_r;
				OFS_R_HI:        o_reg_rdata <= r_hi_r;
				OFS_A_CNT:       o_reg_rdata <= a_r;
				OFS_B_LO:        o_reg_rdata <= b_lo_r;
				OFS_B_HI:        o_reg_rdata <= b_hi_r;
				OFS_PRESCALER:   o_reg_rdata <= psc_r;
				OFS_ABP_STATUS:  o_reg_rdata <= abp_stat_r;
				OFS_LOCK_CFG:    o_reg_rdata <= lock_cfg_r;
				OFS_DELAY_RESET: o_reg_rdata <= dly_rst_r;
				OFS_LD_SEL:      o_reg_rdata <= ld_sel_r;
				OFS_MON_SEL:     o_reg_rdata <= mon_sel_r;
				OFS_LOCK_STATUS: o_reg_rdata <= {5'h00, sync_act, ld_comp, dld_r};
				default:         o_reg_rdata <= 8'h00;
			endcase
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end

	// sync pin counter reset, gated by the two-bit control field
	logic [1:0] sync_mode;
	logic       rst_r_cnt, rst_n_cnt;
	assign sync_mode = dly_rst_r[SYNC_RST_LSB +: 2];
	assign rst_r_cnt = sync_act & (sync_mode == SYNC_RST_ALL | sync_mode == SYNC_RST_R);
	assign rst_n_cnt = sync_act & (sync_mode == SYNC_RST_ALL | sync_mode == SYNC_RST_N);

	// reference divider
	logic [R_W-1:0] r_val, r_div, r_cnt_r;
	logic           r_pulse;
	assign r_val   = {r_hi_r[5:0], r_lo_r};
	assign r_div   = (r_val <= 14'h0001) ? 14'h0001 : r_val;
	// >= so a count left above a newly written, smaller ratio ends at once instead of wrapping
	assign r_pulse = ref_rise & ~rst_r_cnt & (r_cnt_r >= r_div - 14'h0001);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			r_cnt_r <= '0;
		end else if (rst_r_cnt) begin
			r_cnt_r <= '0;
		end else if (ref_rise) begin
			r_cnt_r <= r_pulse ? '0 : r_cnt_r + 14'h0001;
		end
	end

	// prescaler and swallow/main counters
	prescaler_mode_t psc_mode;
	logic       dual_mod;
	logic [5:0] p_val, modulus;
	logic [5:0] psc_cnt_r;
	logic [A_W-1:0] a_val, a_cnt_r;
	logic [B_W-1:0] b_val, b_div, b_cnt_r;
	logic       psc_pulse, n_pulse;

	assign psc_mode = prescaler_mode_t'(psc_r[2:0]);

	always_comb begin
		dual_mod = 1'b1;
		case (psc_mode)
			PSC_FD1: begin
				p_val    = 6'd1;
				dual_mod = 1'b0;
			end
			PSC_FD2: begin
				p_val    = 6'd2;
				dual_mod = 1'b0;
			end
			PSC_FD3: begin
				p_val    = 6'd3;
				dual_mod = 1'b0;
			end
			PSC_DM2:  p_val = 6'd2;
			PSC_DM4:  p_val = 6'd4;
			PSC_DM8:  p_val = 6'd8;
			PSC_DM16: p_val = 6'd16;
			PSC_DM32: p_val = 6'd32;
			default: begin
				p_val    = 6'd1;
				dual_mod = 1'b0;
			end
		endcase
	end

	assign a_val = dual_mod ? a_r[5:0] : '0;
	assign b_val = {b_hi_r[4:0], b_lo_r};
	assign b_div = (b_val == '0) ? 13'h0001 : b_val;
	// swallow cycles use P+1 until A main pulses are done: N = P*B + A
	assign modulus   = (a_cnt_r < a_val) ? p_val + 6'd1 : p_val;
	assign psc_pulse = vco_rise & ~rst_n_cnt & (psc_cnt_r >= modulus - 6'd1);
	assign n_pulse   = psc_pulse & (b_cnt_r >= b_div - 13'h0001);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			psc_cnt_r <= '0;
		end else if (rst_n_cnt) begin
			psc_cnt_r <= '0;
		end else if (vco_rise) begin
			psc_cnt_r <= psc_pulse ? '0 : psc_cnt_r + 6'd1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			b_cnt_r <= '0;
			a_cnt_r <= '0;
		end else if (rst_n_cnt) begin
			b_cnt_r <= '0;
			a_cnt_r <= '0;
		end else if (n_pulse) begin
			b_cnt_r <= '0;
			a_cnt_r <= '0;
		end else if (psc_pulse) begin
			b_cnt_r <= b_cnt_r + 13'h0001;
			if (a_cnt_r < a_val) begin
				a_cnt_r <= a_cnt_r + 6'd1;
			end
		end
	end

	// programmable delay cells, one clock step per code
	logic [DELAY_TAPS-1:0] r_dly_r, n_dly_r;
	logic [2:0] r_code, n_code;
	logic       ref_edge, fb_edge;
	assign r_code = dly_rst_r[RDLY_LSB +: 3];
	assign n_code = dly_rst_r[NDLY_LSB +: 3];

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			r_dly_r <= '0;
			n_dly_r <= '0;
		end else begin
			r_dly_r <= {r_dly_r[DELAY_TAPS-2:0], r_pulse};
			n_dly_r <= {n_dly_r[DELAY_TAPS-2:0], n_pulse};
		end
	end

	assign ref_edge = (r_code == 3'h0) ? r_pulse : r_dly_r[r_code - 3'h1];
	assign fb_edge  = (n_code == 3'h0) ? n_pulse : n_dly_r[n_code - 3'h1];

	// edge spacing measurement between the two detector inputs
	logic [7:0] lock_thr, unlock_thr, need_cnt;
	assign lock_thr   = (lock_cfg_r[LCK_WIN_BIT] ? LOCK_BASE_LOW : LOCK_BASE_HIGH)
		+ {6'h00, abp_stat_r[1:0]};
	assign unlock_thr = {lock_thr[6:0], 1'b0};

	always_comb begin
		case (lock_cfg_r[LCK_CNT_LSB +: 2])
			2'h0:    need_cnt = CNT_NEED_0;
			2'h1:    need_cnt = CNT_NEED_1;
			2'h2:    need_cnt = CNT_NEED_2;
			default: need_cnt = CNT_NEED_3;
		endcase
	end

	phase_state_t ph_r;
	logic [7:0] gap_r;
	logic       res_valid, res_in, res_out;

	// a waiting edge that passes the unlock window closes the cycle as out of window;
	// keeps the next same-side edge from arriving before that happens
	always_comb begin
		res_valid = 1'b0;
		res_in    = 1'b0;
		res_out   = 1'b0;
		case (ph_r)
			PH_IDLE: begin
				if (ref_edge & fb_edge) begin
					res_valid = 1'b1;
					res_in    = 1'b1;
				end
			end
			PH_WAIT_FB, PH_WAIT_REF: begin
				if ((ph_r == PH_WAIT_FB) ? fb_edge : ref_edge) begin
					res_valid = 1'b1;
					res_in    = gap_r < lock_thr;
					res_out   = gap_r > unlock_thr;
				end else if (gap_r > unlock_thr) begin
					res_valid = 1'b1;
					res_out   = 1'b1;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ph_r  <= PH_IDLE;
			gap_r <= '0;
		end else begin
			case (ph_r)
				PH_IDLE: begin
					gap_r <= 8'h01;
					if (ref_edge & ~fb_edge) begin
						ph_r <= PH_WAIT_FB;
					end else if (fb_edge & ~ref_edge) begin
						ph_r <= PH_WAIT_REF;
					end
				end
				PH_WAIT_FB, PH_WAIT_REF: begin
					if (res_valid) begin
						ph_r <= PH_IDLE;
					end else begin
						gap_r <= gap_r + 8'h01;
					end
				end
				default: ph_r <= PH_IDLE;
			endcase
		end
	end

	// digital lock with consecutive-cycle qualification and single-miss release
	logic [7:0] good_cnt_r;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			dld_r      <= 1'b0;
			good_cnt_r <= '0;
		end else if (lock_cfg_r[LCK_DIS_BIT]) begin
			dld_r      <= 1'b0;
			good_cnt_r <= '0;
		end else if (res_valid) begin
			if (!dld_r) begin
				if (res_in) begin
					if (good_cnt_r + 8'h01 >= need_cnt) begin
						dld_r      <= 1'b1;
						good_cnt_r <= '0;
					end else begin
						good_cnt_r <= good_cnt_r + 8'h01;
					end
				end else begin
					good_cnt_r <= '0;
				end
			end else if (res_out) begin
				dld_r <= 1'b0;
			end
		end
	end

	// pin routing; the analog pulse is the time one detector edge waits for the other
	logic pfd_busy;
	assign pfd_busy = (ph_r != PH_IDLE);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_lock_ind <= '{out: 1'b0, oe: 1'b1, src_en: 1'b0};
		end else begin
			case (ld_sel_r[5:0])
				LD_SEL_DLD:     o_lock_ind <= '{out: dld_r, oe: 1'b1, src_en: 1'b0};
				LD_SEL_ALD_NCH: o_lock_ind <= '{out: 1'b0, oe: pfd_busy, src_en: 1'b0};
				LD_SEL_ALD_PCH: o_lock_ind <= '{out: 1'b1, oe: pfd_busy, src_en: 1'b0};
				// ground drive ends charging the moment lock drops
				LD_SEL_CUR_SRC: o_lock_ind <= '{out: 1'b0, oe: ~dld_r, src_en: dld_r};
				default:        o_lock_ind <= '{out: 1'b0, oe: 1'b1, src_en: 1'b0};
			endcase
		end
	end

	function automatic logic mon_pick(input logic [5:0] sel, input logic digital_lock_result,
		input logic comp);
		case (sel)
			MON_SEL_DLD:    mon_pick = digital_lock_result;
			MON_SEL_COMP:   mon_pick = comp;
			MON_SEL_COMP_N: mon_pick = ~comp;
			default:        mon_pick = 1'b0;
		endcase
	endfunction

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_status_pin            <= 1'b0;
			o_reference_monitor_pin <= 1'b0;
			o_pfd_ref_edge          <= 1'b0;
			o_pfd_fb_edge           <= 1'b0;
			o_digital_lock_result   <= 1'b0;
		end else begin
			o_status_pin            <= mon_pick(abp_stat_r[STAT_SEL_LSB +: 6], dld_r, ld_comp);
			o_reference_monitor_pin <= mon_pick({1'b0, mon_sel_r[4:0]}, dld_r, ld_comp);
			o_pfd_ref_edge          <= ref_edge;
			o_pfd_fb_edge           <= fb_edge;
			o_digital_lock_result   <= dld_r;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/pll_lock_pkg.sv */
// register map, field positions, mode codes and timing counts for the pll divider block
// assumes one 50 MHz clock domain and a plain strobed register port
package pll_lock_pkg;
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned DATA_W = 8;

	localparam logic [9:0] OFS_R_LO        = 10'h011;
	localparam logic [9:0] OFS_R_HI        = 10'h012;
	localparam logic [9:0] OFS_A_CNT       = 10'h013;
	localparam logic [9:0] OFS_B_LO        = 10'h014;
	localparam logic [9:0] OFS_B_HI        = 10'h015;
	localparam logic [9:0] OFS_PRESCALER   = 10'h016;
	localparam logic [9:0] OFS_ABP_STATUS  = 10'h017;
	localparam logic [9:0] OFS_LOCK_CFG    = 10'h018;
	localparam logic [9:0] OFS_DELAY_RESET = 10'h019;
	localparam logic [9:0] OFS_LD_SEL      = 10'h01A;
	localparam logic [9:0] OFS_MON_SEL     = 10'h01B;
	localparam logic [9:0] OFS_LOCK_STATUS = 10'h01F;

	localparam int unsigned R_W = 14;
	localparam int unsigned B_W = 13;
	localparam int unsigned A_W = 6;

	// lock_detect_config fields
	localparam int unsigned LCK_CNT_LSB = 5;
	localparam int unsigned LCK_WIN_BIT = 4;
	localparam int unsigned LCK_DIS_BIT = 3;
	// divider_delay_pin_reset_ctrl fields; STAT_SEL_LSB is a field of the OFS_ABP_STATUS register
	localparam int unsigned SYNC_RST_LSB = 6;
	localparam int unsigned RDLY_LSB     = 3;
	localparam int unsigned NDLY_LSB     = 0;
	localparam int unsigned STAT_SEL_LSB = 2;

	localparam logic [1:0] SYNC_RST_OFF  = 2'h0;
	localparam logic [1:0] SYNC_RST_ALL  = 2'h1;
	localparam logic [1:0] SYNC_RST_R    = 2'h2;
	localparam logic [1:0] SYNC_RST_N    = 2'h3;

	localparam logic [5:0] LD_SEL_DLD     = 6'h00;
	localparam logic [5:0] LD_SEL_ALD_NCH = 6'h01;
	localparam logic [5:0] LD_SEL_ALD_PCH = 6'h02;
	localparam logic [5:0] LD_SEL_CUR_SRC = 6'h04;

	localparam logic [5:0] MON_SEL_LOW    = 6'h00;
	localparam logic [5:0] MON_SEL_DLD    = 6'h01;
	localparam logic [5:0] MON_SEL_COMP   = 6'h02;
	localparam logic [5:0] MON_SEL_COMP_N = 6'h03;

	localparam logic [7:0] RST_VAL_REG    = 8'h00;
	localparam logic [2:0] PSC_RST        = 3'h0;

	// phase windows in clock cycles and lock cycle counts; unlock window is lock window doubled
	localparam logic [7:0] LOCK_BASE_HIGH = 8'h08;
	localparam logic [7:0] LOCK_BASE_LOW  = 8'h03;
	localparam logic [7:0] CNT_NEED_0     = 8'h05;
	localparam logic [7:0] CNT_NEED_1     = 8'h10;
	localparam logic [7:0] CNT_NEED_2     = 8'h40;
	localparam logic [7:0] CNT_NEED_3     = 8'hFF;

	// delay cell span: about 1 ns over eight codes, one clock step per code here
	localparam real DELAY_SPAN_NS = 1.0;
	localparam int unsigned DELAY_TAPS = 8;

	typedef enum logic [2:0] {
		PSC_FD1, PSC_FD2, PSC_DM2, PSC_DM4, PSC_DM8, PSC_DM16, PSC_DM32, PSC_FD3
	} prescaler_mode_t;

	typedef enum {PH_IDLE, PH_WAIT_FB, PH_WAIT_REF} phase_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	typedef struct packed {
		logic out;
		logic oe;
		logic src_en;
	} ld_pin_t;
endpackage

/* File: tb/pll_divider_lock_detect_properties.sv */
// port assertions for the divider and lock detect block
// assumes binding onto pll_divider_lock_detect; selects are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module pll_lock_checker
	import pll_lock_pkg::*;
(
	input wire logic                   i_clock,
	input wire logic                   i_rst_n,
	input wire pll_lock_pkg::reg_req_t i_reg_req,
	input wire logic                   i_sync_n_pin,
	input wire logic                   i_lock_ind_in,
	input wire pll_lock_pkg::ld_pin_t  o_lock_ind,
	input wire logic                   o_status_pin,
	input wire logic                   o_reference_monitor_pin,
	input wire logic                   o_pfd_ref_edge,
	input wire logic                   o_pfd_fb_edge,
	input wire logic                   o_digital_lock_result
);
	logic [5:0] ld_r, mon_r, stat_r;
	logic [1:0] cnt_r, syn_r;
	logic [3:0] age_r, dst_r, cst_r, low_r;
	logic [7:0] ref_r, need;
	logic       dld_q, cmp_q;
	wire logic  digital_lock_result = o_digital_lock_result;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			{ld_r, mon_r, stat_r, cnt_r, syn_r} <= '0;
		end else if (i_reg_req.wr) begin
			case (i_reg_req.addr)
				OFS_ABP_STATUS: stat_r <= i_reg_req.wdata[7:2];
				OFS_LOCK_CFG: cnt_r <= i_reg_req.wdata[6:5];
				OFS_DELAY_RESET: syn_r <= i_reg_req.wdata[7:6];
				OFS_LD_SEL: ld_r <= i_reg_req.wdata[5:0];
				OFS_MON_SEL: mon_r <= {1'b0, i_reg_req.wdata[4:0]};
				default: ;
			endcase
		end
	end
	// saturating ages keep in-flight pulses and stale selects out of the checks
	always_ff @(posedge i_clock) begin
		dld_q <= digital_lock_result;
		cmp_q <= i_lock_ind_in;
		age_r <= (!i_rst_n || i_reg_req.wr) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
		dst_r <= (!i_rst_n || dld_q != digital_lock_result) ? 4'h0 : dst_r + {3'h0, dst_r != 4'hF};
		cst_r <= (!i_rst_n || cmp_q != i_lock_ind_in) ? 4'h0 : cst_r + {3'h0, cst_r != 4'hF};
		low_r <= (!i_rst_n || i_sync_n_pin) ? 4'h0 : low_r + {3'h0, low_r != 4'hF};
		ref_r <= (!i_rst_n || digital_lock_result) ? 8'h00 : ref_r + {7'h0, o_pfd_ref_edge && ref_r != 8'hFF};
	end
	always_comb begin
		case (cnt_r)
			2'h0: need = CNT_NEED_0;
			2'h1: need = CNT_NEED_1;
			2'h2: need = CNT_NEED_2;
			default: need = CNT_NEED_3;
		endcase
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	chk_src_drive: assert property (
		ld_r == LD_SEL_CUR_SRC && age_r > 4'h2 && dst_r > 4'h1 |->
		o_lock_ind.src_en == digital_lock_result && o_lock_ind.oe == !digital_lock_result && !o_lock_ind.out)
		else $error("current source drive wrong");
	chk_src_dump: assert property (
		ld_r == LD_SEL_CUR_SRC && age_r > 4'h2 && $fell(digital_lock_result) |->
		##[0:2] (o_lock_ind.oe && !o_lock_ind.src_en && !o_lock_ind.out))
		else $error("pin not discharged on lock loss");
	chk_nch_level: assert property (
		ld_r == LD_SEL_ALD_NCH && age_r > 4'h2 |-> !o_lock_ind.out)
		else $error("pull-down mode drives high");
	chk_pch_level: assert property (
		ld_r == LD_SEL_ALD_PCH && age_r > 4'h2 |-> o_lock_ind.out)
		else $error("pull-up mode drives low");
	chk_status_route: assert property (
		stat_r == 6'h01 && age_r > 4'h2 && dst_r > 4'h1 |-> o_status_pin == digital_lock_result)
		else $error("status pin not lock");
	chk_mon_route: assert property (
		mon_r == 6'h01 && age_r > 4'h2 && dst_r > 4'h1 |-> o_reference_monitor_pin == digital_lock_result)
		else $error("monitor pin not lock");
	chk_comp_route: assert property (
		mon_r[5:1] == 5'h01 && age_r > 4'h2 && cst_r > 4'h7 |->
		o_reference_monitor_pin == (cmp_q ^ mon_r[0]))
		else $error("comparator routing wrong");
	chk_lock_count: assert property (
		$rose(digital_lock_result) |-> ref_r >= need - 8'h01)
		else $error("lock before enough cycles");
	chk_sync_hold: assert property (
		syn_r == SYNC_RST_ALL && age_r == 4'hF && low_r == 4'hF |->
		!o_pfd_ref_edge && !o_pfd_fb_edge)
		else $error("edges during sync reset");
	cover property ($rose(digital_lock_result));
	cover property ($fell(digital_lock_result));
	cover property (ld_r == LD_SEL_CUR_SRC && o_lock_ind.src_en);
	cover property (syn_r == SYNC_RST_ALL && low_r == 4'hF);
endmodule
`default_nettype wire

/* File: tb/lock_pin_capacitor.sv */
// lock indicator pin load: capacitor under the current source, else a resistor pull
// assumes the block's drive fields; charge time counted in clock cycles
`timescale 1ns/1ps
`default_nettype none
module lock_pin_capacitor
	import pll_lock_pkg::*;
#(
	parameter int unsigned CHARGE_CYC = 40
)(
	input  wire logic                  i_clock,
	input  wire pll_lock_pkg::ld_pin_t i_pin,
	input  wire logic                  i_pull_up,
	output logic                       o_level
);
	int unsigned cap_r;
	// a driven low empties the cap at once, so a short lock drop restarts charging
	always_ff @(posedge i_clock) begin
		if (i_pin.oe && !i_pin.out) cap_r <= 0;
		else if (i_pin.src_en && cap_r < CHARGE_CYC) cap_r <= cap_r + 1;
	end
	always_comb begin
		if (i_pin.oe) o_level = i_pin.out;
		else if (i_pin.src_en) o_level = cap_r >= CHARGE_CYC;
		else o_level = i_pull_up;
	end
endmodule
`default_nettype wire

/* File: tb/tb_pll_divider_lock_detect.sv */
// self-checking bench for the divider and lock detect block
// assumes pins toggle with levels of at least four clocks; capacitor model on the lock pin
`timescale 1ns/1ps
`default_nettype none
module tb_pll_divider_lock_detect;
	import pll_lock_pkg::*;
	logic        i_clock = 0, i_rst_n = 0, i_ref_pin = 0, i_vco_pin = 0;
	logic        i_sync_n_pin = 0, pull = 0, frz = 0, rd_d = 0;
	reg_req_t    req = '0;
	logic [7:0]  rdata, tbl[4][4];
	ld_pin_t     ld;
	logic        lk, st, mon, re, fe, digital_lock_result;
	int          error_cnt = 0, compares = 0, t = 0, tv = 0, last = -1, g0, g1;
	logic [31:0] rs = 32'hF2B6;
	logic [7:0]  rd_q[$];
	int          iv_q[$];
	always #10 i_clock = ~i_clock;
	pll_divider_lock_detect i_pll_divider_lock_detect (.i_clock, .i_rst_n, .i_reg_req(req),
		.o_reg_rdata(rdata), .i_ref_pin, .i_vco_pin, .i_sync_n_pin, .i_lock_ind_in(lk),
		.o_lock_ind(ld), .o_status_pin(st), .o_reference_monitor_pin(mon),
		.o_pfd_ref_edge(re), .o_pfd_fb_edge(fe), .o_digital_lock_result(digital_lock_result));
	lock_pin_capacitor i_lock_pin_capacitor (.i_clock, .i_pin(ld), .i_pull_up(pull),
		.o_level(lk));
	// both pins period 16; holding the vco counter makes it lag without short levels
	// a 16-cycle detector period stays above every unlock window used here
	always @(posedge i_clock) begin
		t <= t + 1;
		tv <= frz ? tv : tv + 1;
		i_ref_pin <= (t % 16) < 8;
		i_vco_pin <= (tv % 16) < 8;
		rd_d <= req.rd;
		if (rd_d) check(rdata, rd_q.pop_front());
		if (fe && iv_q.size() > 0 && last >= 0) check(t - last, iv_q.pop_front());
		if (fe) last <= t;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock);
		req <= '0;
		@(posedge i_clock);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] d);
		rd_q.push_back(d);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_clock);
		req <= '0;
		@(posedge i_clock);
	endtask
	task automatic lag(input int n);
		frz <= 1'b1;
		repeat (n) @(posedge i_clock);
		frz <= 1'b0;
	endtask
	task automatic wait_dld(input logic v, input int n);
		for (int i = 0; i < n && digital_lock_result !== v; i++) @(posedge i_clock);
		check(digital_lock_result, v);
	endtask
	task automatic gap(output int g);
		for (int i = 0; i < 99 && re !== 1'b1; i++) @(posedge i_clock);
		for (g = 0; g < 99 && fe !== 1'b1; g++) @(posedge i_clock);
	endtask
	task automatic close_out();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		// ratios keep A below B in the dual-modulus rows, B at least three and rates low
		tbl = '{'{1, 5, 3, 6}, '{2, 1, 3, 7}, '{3, 2, 3, 14}, '{0, 9, 4, 4}};
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		for (int a = 'h17; a <= 'h1B; a++) rd(10'(a), 8'h00);
		rs = lfsr(rs);
		wr(OFS_ABP_STATUS, rs[7:0]);
		rd(OFS_ABP_STATUS, rs[7:0]);
		wr(OFS_DELAY_RESET, {2'h0, rs[13:8]});
		rd(OFS_DELAY_RESET, {2'h0, rs[13:8]});
		rd(10'h3FF, 8'h00);
		$display("register test done");
		wr(OFS_DELAY_RESET, 8'h00);
		wr(OFS_ABP_STATUS, 8'h04);
		wr(OFS_LOCK_CFG, 8'h10);
		wr(OFS_MON_SEL, 8'h01);
		wait_dld(1'b1, 400);
		check(st, 1'b1);
		lag(4);
		repeat (100) @(posedge i_clock);
		check(digital_lock_result, 1'b1);
		lag(4);
		wait_dld(1'b0, 60);
		$display("lock test done");
		wr(OFS_LD_SEL, LD_SEL_CUR_SRC);
		wr(OFS_MON_SEL, 8'h02);
		lag(8);
		wait_dld(1'b1, 400);
		check(mon, 1'b0);
		repeat (60) @(posedge i_clock);
		check(mon, 1'b1);
		lag(8);
		wait_dld(1'b0, 60);
		repeat (10) @(posedge i_clock);
		check(mon, 1'b0);
		wr(OFS_MON_SEL, 8'h03);
		repeat (10) @(posedge i_clock);
		check(mon, 1'b1);
		for (int k = 1; k <= 2; k++) begin
			pull <= (k == 1);
			wr(OFS_LD_SEL, 8'(k));
			repeat (50) @(posedge i_clock);
			check(ld.out, k == 2);
		end
		$display("lock pin test done");
		foreach (tbl[i]) begin
			wr(OFS_PRESCALER, tbl[i][0]);
			wr(OFS_A_CNT, tbl[i][1]);
			wr(OFS_B_LO, tbl[i][2]);
			repeat (300) @(posedge i_clock);
			iv_q.push_back(int'(tbl[i][3]) * 16);
			for (int n = 0; n < 600 && iv_q.size() > 0; n++) @(posedge i_clock);
		end
		wr(OFS_PRESCALER, 8'h00);
		wr(OFS_B_LO, 8'h01);
		repeat (50) @(posedge i_clock);
		gap(g0);
		wr(OFS_DELAY_RESET, 8'h07);
		repeat (50) @(posedge i_clock);
		gap(g1);
		check(g1, g0 + 7);
		wr(OFS_DELAY_RESET, 8'h38);
		repeat (50) @(posedge i_clock);
		gap(g1);
		check(g1, g0 - 7);
		$display("divider test done");
		wr(OFS_DELAY_RESET, 8'h40);
		repeat (30) @(posedge i_clock);
		g1 = 0;
		repeat (40) @(posedge i_clock) g1 += re | fe;
		check(g1, 0);
		i_sync_n_pin <= 1'b1;
		gap(g1);
		check(g1, g0);
		$display("sync test done");
		close_out();
	end
	initial begin
		#400000;
		error_cnt++;
		close_out();
	end
endmodule
bind pll_divider_lock_detect pll_lock_checker i_pll_lock_checker (.i_clock, .i_rst_n,
	.i_reg_req, .i_sync_n_pin, .i_lock_ind_in, .o_lock_ind, .o_status_pin,
	.o_reference_monitor_pin, .o_pfd_ref_edge, .o_pfd_fb_edge, .o_digital_lock_result);
`default_nettype wire
